// ==== iopc_pkg.sv ====
// package: offsets, reset values and carriers of the config bank
package iopc_pkg;
  localparam logic [7:0] IDX_PWR = 8'h06;
  localparam logic [7:0] IDX_CLK = 8'h07;
  localparam logic [7:0] IDX_ID = 8'h08;
  localparam logic [7:0] IDX_ADV = 8'h09;
  localparam logic [7:0] PWR_RST = 8'h00;
  // strap, status bits filled in at run time
  localparam logic [7:0] CLK_RST = 8'h00;
  localparam logic [7:0] ADV_RST = 8'hC0;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;
  // writable masks; read-only bits keep their source
  localparam logic [7:0] CLK_WMASK = 8'h9F;
  localparam logic [7:0] ADV_WMASK = 8'hF7;
  localparam int PWR_IDE = 0;
  localparam int PWR_FDC = 1;
  localparam int PWR_UART = 2;
  localparam int PWR_PDMA = 3;
  localparam int PWR_STAT = 4;
  localparam int PWR_SLOCK = 5;
  localparam int PWR_PAR = 6;
  localparam int CLK_HALF = 0;
  localparam int CLK_FAST = 1;
  localparam int CLK_EPPTO = 2;
  localparam int CLK_U1 = 3;
  localparam int CLK_U2 = 4;
  localparam int CLK_PDST = 5;
  localparam int CLK_IDST = 6;
  localparam int CLK_IDMSK = 7;
  localparam int ADV_RATE = 0;
  localparam int ADV_D23 = 1;
  localparam int ADV_DRID = 2;
  localparam int ADV_PNF = 3;
  localparam int ADV_MODE_LO = 6;
  localparam logic [3:0] BAUD_DIV_STD = 4'hD;
  localparam logic [3:0] BAUD_DIV_MIDI = 4'hC;
  typedef enum logic [1:0] {
    IOPC_MODE_LEGACY_A = 2'h0,
    IOPC_MODE_LEGACY_B = 2'h1,
    IOPC_MODE_ILLEGAL = 2'h2,
    IOPC_MODE_STANDARD = 2'h3
  } iopc_mode_e;
  // modem inputs of one serial port
  typedef struct packed {
    logic sin;
    logic cts_n;
    logic dsr_n;
    logic dcd_n;
    logic ri_n;
  } iopc_ser_s;
  localparam iopc_ser_s SER_BLOCKED = 5'h1F;
  // printer status inputs
  typedef struct packed {
    logic busy;
    logic pe;
    logic slct;
    logic ack_n;
    logic err_n;
  } iopc_par_s;
  localparam iopc_par_s PAR_BLOCKED = 5'h13;
  // host index/data port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic sel_data;
    logic [7:0] wdata;
  } iopc_host_s;
endpackage : iopc_pkg

// ==== iopc_regs.sv ====
// pin and power configuration registers behind the index/data port
// Notes on behaviour
// - power register at index 06h, all bits zero after reset.
// - power bit 0 floats disk selects, blocks data bit 7 when idle.
// - power bit 1 floats floppy outputs, blocks inputs when powered down.
// - power bit 2 floats idle serial port, inputs read as all ones.
// - power bit 3 picks parallel DMA acknowledge/request versus identify.
// - power bit 4 swaps second-drive pins to idle and power-down.
// - power bit 5 freezes lockable bits until hardware reset.
// - power bit 6 floats idle parallel port, forces fixed status inputs.
// - index 07h resets to 0XX0000X, bit 0 takes clock strap.
// - halving bit runs modules and floppy at half oscillator rate.
// - fast bit runs floppy at full rate; software sets halving too.
// - bit 2 gates parallel timeout interrupt onto selected line.
// - bits 3/4 pick baud prescale thirteen or twelve per port.
// - bits 5 and 6 always show floppy power-down and idle.
// - bit 7 drives idle pin low, else pin follows idle.
// - read-only identification at 08h, upper five bits chip code.
// - index 09h resets bits 0-2,5 low and bits 6-7 high.
// - advanced bit 0 makes rate open-drain pin, parallel irq forced.
// - advanced bit 1 makes combined drive 2/3 select, third drive one.
// - advanced bit 2 makes ident inputs, 16-bit cycle active.
// - advanced bit 3 read-only sense, one when floppy powered down.
// - advanced bits 7:6 select system mode, code 10 illegal.
`timescale 1ns/1ps
`default_nettype none
module iopc_regs
  import iopc_pkg::*;
#(
  parameter logic [4:0] CHIP_CODE = 5'h13, // arbitrary value
  parameter logic [2:0] CHIP_REV = 3'h0 // arbitrary value
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire iopc_host_s host_req,
  output logic [7:0] host_rdata,
  input wire logic global_lock,
  output logic selective_lock,
  input wire logic clk_sel_strap,
  input wire logic chip_powerdown,
  input wire logic ide_disabled,
  input wire logic fdc_powerdown,
  input wire logic [1:0] uart_powerdown,
  input wire logic par_disabled,
  input wire logic fdc_idle,
  input wire logic floppy_powerdown_flag,
  input wire logic mtr1_n,
  input wire logic dr1_n,
  input wire logic rate_output_zero,
  input wire logic drive2_sel,
  input wire logic drive3_sel,
  input wire logic par_irq,
  input wire logic epp_timeout,
  input wire logic par_irq7_sel,
  input wire logic parallel_dma_request,
  input wire iopc_ser_s ser1_pins,
  input wire iopc_ser_s ser2_pins,
  input wire iopc_par_s par_pins,
  input wire logic disk_data_bit_seven,
  input wire logic dack_ident_pin,
  input wire logic printer_or_floppy_sense,
  input wire logic third_drive_present_input,
  input wire logic drive_ident_bit_zero,
  input wire logic drive_ident_bit_one,
  input wire logic sixteen_bit_cycle_n,
  output logic disk_cs_oe,
  output logic disk_d7_int,
  output logic fdc_out_oe,
  output logic fdc_in_block,
  output logic [1:0] ser_out_oe,
  output iopc_ser_s ser1_int,
  output iopc_ser_s ser2_int,
  output logic par_out_oe,
  output iopc_par_s par_int,
  output logic parallel_dma_acknowledge,
  output logic par_ident,
  output logic parallel_dma_request_out,
  output logic parallel_dma_request_oe,
  output logic pin_mtr1_idle,
  output logic pin_dr1_pd,
  output logic oscillator_halving_enable,
  output logic mod_clk_en,
  output logic fdc_clk_en,
  output logic fdc_fast_rate,
  output logic [1:0] baud_clk_en,
  output logic irq5_out,
  output logic irq5_oe,
  output logic irq7_out,
  output logic drive_two_three_select_n,
  output logic pin49_oe,
  output logic third_drive_int,
  output logic disk_pins_oe,
  output logic [1:0] drive_ident,
  output logic sixteen_bit_cycle_indication,
  output iopc_mode_e sys_mode,
  output logic mode_illegal
);

  function automatic logic [3:0] baud_next(input logic [3:0] cnt,
                                           input logic midi);
    logic [3:0] lim;
    lim = midi ? BAUD_DIV_MIDI : BAUD_DIV_STD;
    baud_next = (cnt >= lim - 4'h1) ? 4'h0 : cnt + 4'h1;
  endfunction : baud_next

  logic [7:0] index_ff;
  logic [7:0] pwr_ff;
  logic [7:0] clk_ff;
  logic [7:0] adv_ff;
  logic strap_cap_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic [7:0] clk_view;
  logic [7:0] adv_view;
  logic wr_data;
  logic lock_all;
  logic half_ff;
  logic [3:0] baud1_ff;
  logic [3:0] baud2_ff;

  // two-stage synchronisers for pin inputs
  // no reset: strap level is settled by the time reset lifts
  logic [22:0] meta_ff;
  logic [22:0] sync_ff;
  logic [22:0] pin_vec;
  assign pin_vec = {clk_sel_strap, ser1_pins, ser2_pins, par_pins,
                    disk_data_bit_seven, dack_ident_pin,
                    printer_or_floppy_sense, third_drive_present_input,
                    drive_ident_bit_zero, drive_ident_bit_one,
                    sixteen_bit_cycle_n};
  always_ff @(posedge clk_sys) begin
    meta_ff <= pin_vec;
    sync_ff <= meta_ff;
  end
  logic s_strap;
  iopc_ser_s s_ser1;
  iopc_ser_s s_ser2;
  iopc_par_s s_par;
  logic s_d7;
  logic s_dack;
  logic s_pnf;
  logic s_third_drive_present_input;
  logic s_id0;
  logic s_id1;
  logic s_cs16_n;
  assign s_strap = sync_ff[22];
  assign s_ser1 = sync_ff[21:17];
  assign s_ser2 = sync_ff[16:12];
  assign s_par = sync_ff[11:7];
  assign s_d7 = sync_ff[6];
  assign s_dack = sync_ff[5];
  assign s_pnf = sync_ff[4];
  assign s_third_drive_present_input = sync_ff[3];
  assign s_id0 = sync_ff[2];
  assign s_id1 = sync_ff[1];
  assign s_cs16_n = sync_ff[0];

  // global lock honoured only while selective lock is clear
  assign lock_all = global_lock & ~pwr_ff[PWR_SLOCK];
  assign wr_data = host_req.wr & host_req.sel_data & ~lock_all;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      index_ff <= 8'h00;
    end else if (host_req.wr && !host_req.sel_data) begin
      index_ff <= host_req.wdata;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pwr_ff <= PWR_RST;
    end else if (wr_data && index_ff == IDX_PWR) begin
      pwr_ff <= host_req.wdata;
      if (pwr_ff[PWR_SLOCK]) begin
        pwr_ff[PWR_SLOCK] <= 1'b1;
      end
    end
  end

  // strap caught at first edge after release
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      strap_cap_ff <= 1'b1;
    end else begin
      strap_cap_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      clk_ff <= CLK_RST;
    end else if (strap_cap_ff) begin
      clk_ff[CLK_HALF] <= s_strap;
    end else if (wr_data && index_ff == IDX_CLK) begin
      clk_ff <= (host_req.wdata & CLK_WMASK) | (clk_ff & ~CLK_WMASK);
      if (pwr_ff[PWR_SLOCK]) begin
        clk_ff[CLK_HALF] <= clk_ff[CLK_HALF];
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      adv_ff <= ADV_RST;
    end else if (wr_data && index_ff == IDX_ADV) begin
      adv_ff <= (host_req.wdata & ADV_WMASK) | (adv_ff & ~ADV_WMASK);
    end
  end

  always_comb begin
    clk_view = clk_ff;
    clk_view[CLK_PDST] = floppy_powerdown_flag;
    clk_view[CLK_IDST] = fdc_idle;
  end

  always_comb begin
    adv_view = adv_ff;
    adv_view[ADV_PNF] = fdc_powerdown | s_pnf;
  end

  always_comb begin
    if (!host_req.sel_data) begin
      nxt_rdata = index_ff;
    end else if (index_ff == IDX_PWR) begin
      nxt_rdata = pwr_ff;
    end else if (index_ff == IDX_CLK) begin
      nxt_rdata = clk_view;
    end else if (index_ff == IDX_ID) begin
      nxt_rdata = {CHIP_CODE, CHIP_REV};
    end else if (index_ff == IDX_ADV) begin
      nxt_rdata = adv_view;
    end else begin
      nxt_rdata = UNMAPPED_RD;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_ff <= 8'h00;
    end else if (host_req.rd) begin
      rdata_ff <= nxt_rdata;
    end
  end
  assign host_rdata = rdata_ff;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      half_ff <= 1'b0;
      mod_clk_en <= 1'b0;
      fdc_clk_en <= 1'b0;
    end else begin
      half_ff <= ~half_ff;
      mod_clk_en <= ~clk_ff[CLK_HALF] | half_ff;
      fdc_clk_en <= clk_ff[CLK_FAST] | ~clk_ff[CLK_HALF] | half_ff;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      baud1_ff <= 4'h0;
      baud2_ff <= 4'h0;
      baud_clk_en <= 2'h0;
    end else begin
      baud_clk_en <= 2'h0;
      if (mod_clk_en) begin
        baud1_ff <= baud_next(baud1_ff, clk_ff[CLK_U1]);
        baud2_ff <= baud_next(baud2_ff, clk_ff[CLK_U2]);
        baud_clk_en <= {baud2_ff == 4'h0, baud1_ff == 4'h0};
      end
    end
  end

  logic ide_float;
  logic par_float;
  logic [1:0] ser_float;
  logic fdc_float;
  assign ide_float = pwr_ff[PWR_IDE] & (ide_disabled | chip_powerdown);
  assign fdc_float = pwr_ff[PWR_FDC] & fdc_powerdown;
  assign ser_float = {2{pwr_ff[PWR_UART]}} & uart_powerdown;
  assign par_float = pwr_ff[PWR_PAR] & (par_disabled | chip_powerdown);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      disk_cs_oe <= 1'b1;
      disk_d7_int <= 1'b0;
      fdc_out_oe <= 1'b1;
      fdc_in_block <= 1'b0;
    end else begin
      disk_cs_oe <= ~ide_float;
      disk_d7_int <= ide_float ? 1'b0 : s_d7;
      fdc_out_oe <= ~fdc_float;
      fdc_in_block <= fdc_float;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ser_out_oe <= 2'h3;
      ser1_int <= SER_BLOCKED;
      ser2_int <= SER_BLOCKED;
    end else begin
      ser_out_oe <= ~ser_float;
      ser1_int <= ser_float[0] ? SER_BLOCKED : s_ser1;
      ser2_int <= ser_float[1] ? SER_BLOCKED : s_ser2;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      par_out_oe <= 1'b1;
      par_int <= PAR_BLOCKED;
    end else begin
      par_out_oe <= ~par_float;
      par_int <= par_float ? PAR_BLOCKED : s_par;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      parallel_dma_acknowledge <= 1'b1;
      par_ident <= 1'b1;
      parallel_dma_request_out <= 1'b0;
      parallel_dma_request_oe <= 1'b0;
    end else begin
      parallel_dma_acknowledge <= pwr_ff[PWR_PDMA] ? s_dack : 1'b1;
      // identify reads one whichever way the pin is used
      par_ident <= 1'b1;
      parallel_dma_request_out <= parallel_dma_request;
      parallel_dma_request_oe <= pwr_ff[PWR_PDMA];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_mtr1_idle <= 1'b1;
      pin_dr1_pd <= 1'b1;
    end else if (pwr_ff[PWR_STAT]) begin
      pin_mtr1_idle <= clk_ff[CLK_IDMSK] ? 1'b0 : fdc_idle;
      pin_dr1_pd <= floppy_powerdown_flag;
    end else begin
      pin_mtr1_idle <= mtr1_n;
      pin_dr1_pd <= dr1_n;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      oscillator_halving_enable <= 1'b0;
      fdc_fast_rate <= 1'b0;
      selective_lock <= 1'b0;
      sys_mode <= IOPC_MODE_STANDARD;
      mode_illegal <= 1'b0;
    end else begin
      oscillator_halving_enable <= clk_ff[CLK_HALF];
      fdc_fast_rate <= clk_ff[CLK_FAST];
      selective_lock <= pwr_ff[PWR_SLOCK];
      sys_mode <= iopc_mode_e'(adv_ff[ADV_MODE_LO +: 2]);
      mode_illegal <= adv_ff[ADV_MODE_LO +: 2] == IOPC_MODE_ILLEGAL;
    end
  end

  logic par_irq_q;
  assign par_irq_q = par_irq | (clk_ff[CLK_EPPTO] & epp_timeout);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq5_out <= 1'b0;
      irq5_oe <= 1'b1;
      irq7_out <= 1'b0;
    end else if (adv_ff[ADV_RATE]) begin
      irq5_out <= 1'b0;
      irq5_oe <= ~rate_output_zero;
      irq7_out <= par_irq_q;
    end else begin
      irq5_out <= par_irq_q & ~par_irq7_sel;
      irq5_oe <= 1'b1;
      irq7_out <= par_irq_q & par_irq7_sel;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      drive_two_three_select_n <= 1'b1;
      pin49_oe <= 1'b0;
      third_drive_int <= 1'b1;
    end else begin
      drive_two_three_select_n <= ~(drive2_sel | drive3_sel);
      pin49_oe <= adv_ff[ADV_D23];
      third_drive_int <= adv_ff[ADV_D23] ? 1'b1 : s_third_drive_present_input;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      disk_pins_oe <= 1'b1;
      drive_ident <= 2'h0;
      sixteen_bit_cycle_indication <= 1'b0;
    end else begin
      disk_pins_oe <= ~adv_ff[ADV_DRID];
      drive_ident <= adv_ff[ADV_DRID] ? {s_id1, s_id0} : 2'h0;
      sixteen_bit_cycle_indication <= adv_ff[ADV_DRID] | ~s_cs16_n;
    end
  end

  // checks
  property p_pwr_write;
    @(posedge clk_sys) disable iff (rst)
    wr_data && index_ff == IDX_PWR && !pwr_ff[PWR_SLOCK]
      |=> pwr_ff == $past(host_req.wdata);
  endproperty
  a_pwr_write: assert property (p_pwr_write)
    else $error("power write lost");

  property p_ide_float;
    @(posedge clk_sys) disable iff (rst)
    ide_float |=> !disk_cs_oe && !disk_d7_int;
  endproperty
  a_ide_float: assert property (p_ide_float)
    else $error("disk selects not floated");

  property p_ser_block;
    @(posedge clk_sys) disable iff (rst)
    ser_float[0] |=> ser1_int == SER_BLOCKED && !ser_out_oe[0];
  endproperty
  a_ser_block: assert property (p_ser_block)
    else $error("serial inputs not blocked");

  property p_lock_sticks;
    @(posedge clk_sys) disable iff (rst)
    pwr_ff[PWR_SLOCK] |=> pwr_ff[PWR_SLOCK] && $stable(clk_ff[CLK_HALF]);
  endproperty
  a_lock_sticks: assert property (p_lock_sticks)
    else $error("locked bits changed");

  property p_par_block;
    @(posedge clk_sys) disable iff (rst)
    par_float |=> par_int == PAR_BLOCKED && !par_out_oe;
  endproperty
  a_par_block: assert property (p_par_block)
    else $error("parallel inputs not blocked");

  property p_half_rate;
    @(posedge clk_sys) disable iff (rst)
    clk_ff[CLK_HALF] && $stable(clk_ff[CLK_HALF]) && mod_clk_en
      |=> !mod_clk_en;
  endproperty
  a_half_rate: assert property (p_half_rate)
    else $error("module enable not halved");

  property p_epp_mask;
    @(posedge clk_sys) disable iff (rst)
    !par_irq && !clk_ff[CLK_EPPTO] |=> !irq5_out && !irq7_out;
  endproperty
  a_epp_mask: assert property (p_epp_mask)
    else $error("masked timeout raised irq");

  property p_baud_gap;
    @(posedge clk_sys) disable iff (rst)
    baud_clk_en[0] |=> !baud_clk_en[0] [*3];
  endproperty
  a_baud_gap: assert property (p_baud_gap)
    else $error("baud enable too frequent");

  property p_idle_mask;
    @(posedge clk_sys) disable iff (rst)
    pwr_ff[PWR_STAT] && clk_ff[CLK_IDMSK] |=> !pin_mtr1_idle;
  endproperty
  a_idle_mask: assert property (p_idle_mask)
    else $error("masked idle pin high");

  property p_id_read;
    @(posedge clk_sys) disable iff (rst)
    host_req.rd && host_req.sel_data && index_ff == IDX_ID
      |=> host_rdata[7:3] == CHIP_CODE;
  endproperty
  a_id_read: assert property (p_id_read)
    else $error("wrong id code");

  property p_rate_pin;
    @(posedge clk_sys) disable iff (rst)
    adv_ff[ADV_RATE] && $stable(adv_ff) |=> !irq5_out;
  endproperty
  a_rate_pin: assert property (p_rate_pin)
    else $error("rate pin drives high");

  property p_mode;
    @(posedge clk_sys) disable iff (rst)
    1'b1 |=> mode_illegal ==
      ($past(adv_ff[ADV_MODE_LO +: 2]) == IOPC_MODE_ILLEGAL);
  endproperty
  a_mode: assert property (p_mode)
    else $error("illegal mode flag wrong");

  c_lock: cover property (@(posedge clk_sys) disable iff (rst)
    $rose(pwr_ff[PWR_SLOCK]));
  c_fast: cover property (@(posedge clk_sys) disable iff (rst)
    clk_ff[CLK_FAST] && clk_ff[CLK_HALF]);
  c_float: cover property (@(posedge clk_sys) disable iff (rst)
    par_float ##1 ser_float != 2'h0);

endmodule : iopc_regs
`default_nettype wire

// ==== iopc_tb.sv ====
// self-checking bench for the pin and power configuration bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  import iopc_pkg::*;
  localparam logic [4:0] ID_CODE = 5'h0B; // arbitrary value
  logic clk_sys, rst, global_lock, selective_lock, clk_sel_strap;
  logic chip_powerdown, ide_disabled, fdc_powerdown, par_disabled, fdc_idle;
  logic floppy_powerdown_flag, mtr1_n, dr1_n, rate_output_zero, drive2_sel;
  logic drive3_sel, par_irq, epp_timeout, par_irq7_sel, parallel_dma_request;
  logic disk_data_bit_seven, dack_ident_pin, printer_or_floppy_sense;
  logic third_drive_present_input, drive_ident_bit_zero, drive_ident_bit_one;
  logic sixteen_bit_cycle_n, disk_cs_oe, disk_d7_int, fdc_out_oe;
  logic fdc_in_block, par_out_oe, parallel_dma_acknowledge, par_ident;
  logic parallel_dma_request_out, parallel_dma_request_oe, pin_mtr1_idle, pin_dr1_pd, mod_clk_en, fdc_clk_en;
  logic oscillator_halving_enable, fdc_fast_rate, irq5_out, irq5_oe;
  logic irq7_out, pin49_oe, drive_two_three_select_n, third_drive_int;
  logic disk_pins_oe, sixteen_bit_cycle_indication, mode_illegal;
  logic [1:0] uart_powerdown, ser_out_oe, baud_clk_en, drive_ident;
  logic [7:0] host_rdata, rd_val;
  iopc_host_s host_req;
  iopc_ser_s ser1_pins, ser2_pins, ser1_int, ser2_int;
  iopc_par_s par_pins, par_int;
  iopc_mode_e sys_mode;
  int bad_count, n_compared, cyc, n_mod, n_fdc, n_b0, n_b1;

  iopc_regs #(.CHIP_CODE(ID_CODE), .CHIP_REV(3'h0)) dut (
    .clk_sys, .rst, .host_req, .host_rdata, .global_lock, .selective_lock,
    .clk_sel_strap, .chip_powerdown, .ide_disabled, .fdc_powerdown,
    .uart_powerdown, .par_disabled, .fdc_idle, .floppy_powerdown_flag,
    .mtr1_n, .dr1_n, .rate_output_zero, .drive2_sel, .drive3_sel, .par_irq,
    .epp_timeout, .par_irq7_sel, .parallel_dma_request, .ser1_pins,
    .ser2_pins, .par_pins, .disk_data_bit_seven, .dack_ident_pin,
    .printer_or_floppy_sense, .third_drive_present_input,
    .drive_ident_bit_zero, .drive_ident_bit_one, .sixteen_bit_cycle_n,
    .disk_cs_oe, .disk_d7_int, .fdc_out_oe, .fdc_in_block, .ser_out_oe,
    .ser1_int, .ser2_int, .par_out_oe, .par_int, .parallel_dma_acknowledge,
    .par_ident, .parallel_dma_request_out, .parallel_dma_request_oe, .pin_mtr1_idle, .pin_dr1_pd,
    .oscillator_halving_enable, .mod_clk_en, .fdc_clk_en, .fdc_fast_rate,
    .baud_clk_en, .irq5_out, .irq5_oe, .irq7_out, .drive_two_three_select_n,
    .pin49_oe, .third_drive_int, .disk_pins_oe, .drive_ident,
    .sixteen_bit_cycle_indication, .sys_mode, .mode_illegal
  );

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      results();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic cmp(input string n, input logic [15:0] e, logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %s expected %0h seen %0h", n, e, g);
    end
  endtask : cmp

  task automatic chk_pin(input string n, input logic e, input logic g);
    cmp(n, {15'h0, e}, {15'h0, g});
  endtask : chk_pin

  task automatic chk_val(input string n, input int e, input logic [7:0] g);
    cmp(n, 16'(e), {8'h0, g});
  endtask : chk_val

  // one bus cycle; caller idles the port afterwards
  task automatic put(input logic s, input logic [7:0] d, input logic r);
    host_req = '{wr: ~r, rd: r, sel_data: s, wdata: d};
    tick(1);
  endtask : put

  task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
    put(1'b0, idx, 1'b0);
    put(1'b1, d, 1'b0);
    host_req = '0;
    tick(2);
  endtask : wreg

  task automatic chk_reg(input logic [7:0] idx, input logic [7:0] e);
    put(1'b0, idx, 1'b0);
    put(1'b1, 8'h00, 1'b1);
    rd_val = host_rdata;
    host_req = '0;
    tick(1);
    cmp("register", {8'h0, e}, {8'h0, rd_val});
  endtask : chk_reg

  task automatic cnt(input int e_mod, e_fdc, e_b0, e_b1);
    {n_mod, n_fdc, n_b0, n_b1} = '0;
    repeat (312) begin
      tick(1);
      n_mod += mod_clk_en;
      n_fdc += fdc_clk_en;
      n_b0 += baud_clk_en[0];
      n_b1 += baud_clk_en[1];
    end
    cmp("mod_clk_en", 16'(e_mod), 16'(n_mod));
    cmp("fdc_clk_en", 16'(e_fdc), 16'(n_fdc));
    cmp("baud0", 16'(e_b0), 16'(n_b0));
    cmp("baud1", 16'(e_b1), 16'(n_b1));
  endtask : cnt

  initial begin
    {global_lock, clk_sel_strap, chip_powerdown, ide_disabled} = '0;
    {fdc_powerdown, uart_powerdown, par_disabled, fdc_idle} = '0;
    {floppy_powerdown_flag, rate_output_zero, drive2_sel, drive3_sel} = '0;
    {par_irq, epp_timeout, par_irq7_sel, parallel_dma_request} = '0;
    {disk_data_bit_seven, dack_ident_pin, printer_or_floppy_sense} = '0;
    {drive_ident_bit_zero, drive_ident_bit_one, sixteen_bit_cycle_n} = 3'h1;
    {third_drive_present_input, mtr1_n, dr1_n} = 3'h7;
    {ser1_pins, ser2_pins, par_pins, host_req} = '0;
    {bad_count, n_compared, cyc} = '0;
    rst = 1'b1;
    tick(20);
    rst = 1'b0;
    tick(2);
    chk_reg(IDX_PWR, PWR_RST);
    chk_reg(IDX_CLK, 8'h00);
    chk_reg(IDX_ID, {ID_CODE, 3'h0});
    chk_reg(IDX_ADV, 8'hC0);
    wreg(IDX_ID, 8'hFF);
    chk_reg(IDX_ID, {ID_CODE, 3'h0});
    wreg(8'h0A, 8'h5A);
    chk_reg(8'h0A, UNMAPPED_RD);
    wreg(IDX_CLK, 8'h60);
    chk_reg(IDX_CLK, 8'h00);
    {floppy_powerdown_flag, fdc_idle} = 2'h3;
    tick(2);
    chk_reg(IDX_CLK, 8'h60);
    {floppy_powerdown_flag, fdc_idle} = 2'h0;
    // clock enables and baud prescalers
    wreg(IDX_CLK, 8'h10);
    cnt(312, 312, 24, 26);
    wreg(IDX_CLK, 8'h09);
    cnt(156, 156, 13, 12);
    wreg(IDX_CLK, 8'h03);
    cnt(156, 312, 12, 12);
    chk_pin("fast", 1'b1, fdc_fast_rate);
    chk_pin("half", 1'b1, oscillator_halving_enable);
    // parallel timeout interrupt and line choice
    {epp_timeout, par_irq7_sel} = 2'h3;
    wreg(IDX_CLK, 8'h00);
    chk_pin("irq7", 1'b0, irq7_out);
    wreg(IDX_CLK, 8'h04);
    chk_pin("irq7", 1'b1, irq7_out);
    par_irq7_sel = 1'b0;
    tick(2);
    chk_pin("irq5", 1'b1, irq5_out);
    rate_output_zero = 1'b1;
    wreg(IDX_ADV, 8'hC1);
    chk_pin("irq7", 1'b1, irq7_out);
    chk_pin("irq5_oe", 1'b0, irq5_oe);
    chk_pin("irq5", 1'b0, irq5_out);
    rate_output_zero = 1'b0;
    tick(2);
    chk_pin("irq5_oe", 1'b1, irq5_oe);
    {drive3_sel, third_drive_present_input} = 2'h2;
    wreg(IDX_ADV, 8'hC2);
    chk_pin("drive_two_three_select", 1'b0, drive_two_three_select_n);
    chk_pin("third", 1'b1, third_drive_int);
    chk_pin("pin49_oe", 1'b1, pin49_oe);
    drive3_sel = 1'b0;
    tick(2);
    chk_pin("drive_two_three_select", 1'b1, drive_two_three_select_n);
    {drive_ident_bit_zero, drive_ident_bit_one} = 2'h3;
    wreg(IDX_ADV, 8'hC4);
    tick(2);
    chk_pin("sixteen_bit_cycle_indication", 1'b1, sixteen_bit_cycle_indication);
    chk_val("ident", 3, 8'(drive_ident));
    chk_pin("disk_oe", 1'b0, disk_pins_oe);
    chk_pin("third", 1'b0, third_drive_int);
    printer_or_floppy_sense = 1'b1;
    wreg(IDX_ADV, 8'hC0);
    tick(2);
    chk_pin("sixteen_bit_cycle_indication", 1'b0, sixteen_bit_cycle_indication);
    chk_reg(IDX_ADV, 8'hC8);
    {printer_or_floppy_sense, fdc_powerdown} = 2'h1;
    tick(4);
    chk_reg(IDX_ADV, 8'hC8);
    for (int m = 0; m < 4; m++) begin
      wreg(IDX_ADV, {m[1:0], 6'h00});
      chk_val("mode", m, 8'(sys_mode));
      chk_pin("illegal", m == 2, mode_illegal);
    end
    // pin float and input blocking
    {ide_disabled, uart_powerdown, par_disabled} = 4'hB;
    {ser2_pins, par_pins, parallel_dma_request, disk_data_bit_seven} =
      {5'h0A, 5'h0C, 2'h3};
    wreg(IDX_PWR, 8'h01);
    chk_pin("cs_oe", 1'b0, disk_cs_oe);
    chk_pin("d7", 1'b0, disk_d7_int);
    {ide_disabled, chip_powerdown} = 2'h1;
    tick(2);
    chk_pin("cs_oe", 1'b0, disk_cs_oe);
    chk_pin("parallel_dma_request_oe", 1'b0, parallel_dma_request_oe);
    chk_pin("ident", 1'b1, par_ident);
    chk_pin("parallel_dma_acknowledge", 1'b1, parallel_dma_acknowledge);
    chip_powerdown = 1'b0;
    wreg(IDX_PWR, 8'h4E);
    tick(2);
    chk_pin("cs_oe", 1'b1, disk_cs_oe);
    chk_pin("fdc_oe", 1'b0, fdc_out_oe);
    chk_pin("fdc_blk", 1'b1, fdc_in_block);
    chk_val("ser_oe", 2, 8'(ser_out_oe));
    chk_val("ser1", 8'h1F, 8'(ser1_int));
    chk_val("ser2", 8'h0A, 8'(ser2_int));
    chk_pin("par_oe", 1'b0, par_out_oe);
    chk_val("par", 8'h13, 8'(par_int));
    chk_pin("parallel_dma_request_oe", 1'b1, parallel_dma_request_oe);
    chk_pin("parallel_dma_request", 1'b1, parallel_dma_request_out);
    chk_pin("parallel_dma_acknowledge", 1'b0, parallel_dma_acknowledge);
    chk_pin("d7", 1'b1, disk_d7_int);
    {fdc_powerdown, uart_powerdown, par_disabled} = '0;
    tick(2);
    chk_val("par", 8'h0C, 8'(par_int));
    chk_pin("fdc_oe", 1'b1, fdc_out_oe);
    {fdc_idle, floppy_powerdown_flag, mtr1_n, dr1_n} = 4'hC;
    wreg(IDX_PWR, 8'h10);
    chk_pin("idle", 1'b1, pin_mtr1_idle);
    chk_pin("pd", 1'b1, pin_dr1_pd);
    wreg(IDX_CLK, 8'h80);
    chk_pin("idle", 1'b0, pin_mtr1_idle);
    wreg(IDX_PWR, 8'h00);
    chk_pin("mtr1", 1'b0, pin_mtr1_idle);
    chk_pin("dr1", 1'b0, pin_dr1_pd);
    // global then selective lock
    {fdc_idle, floppy_powerdown_flag, global_lock} = 3'h1;
    wreg(IDX_PWR, 8'h02);
    chk_reg(IDX_PWR, 8'h00);
    global_lock = 1'b0;
    wreg(IDX_CLK, 8'h01);
    wreg(IDX_PWR, 8'h20);
    wreg(IDX_PWR, 8'h00);
    chk_reg(IDX_PWR, 8'h20);
    chk_pin("slock", 1'b1, selective_lock);
    wreg(IDX_CLK, 8'h00);
    chk_reg(IDX_CLK, 8'h01);
    global_lock = 1'b1;
    wreg(IDX_PWR, 8'h21);
    chk_reg(IDX_PWR, 8'h21);
    global_lock = 1'b0;
    clk_sel_strap = 1'b1;
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    tick(2);
    chk_reg(IDX_PWR, 8'h00);
    chk_pin("slock", 1'b0, selective_lock);
    chk_reg(IDX_CLK, 8'h01);
    results();
  end
endmodule : tb
`default_nettype wire
